// [pkg/tlbd_defines.vh]
`ifndef TLBD_DEFINES_VH
`define TLBD_DEFINES_VH

// Register indices on the plain register port.
`define TLBD_REG_UPPER 4'h0
`define TLBD_REG_LOWER 4'h1
`define TLBD_REG_HYST 4'h2
`define TLBD_REG_WAIT 4'h3
`define TLBD_REG_DEVLIM 4'h4
`define TLBD_REG_ACTION 4'h5
`define TLBD_REG_TERM 4'h6
`define TLBD_REG_CTRL 4'h7
`define TLBD_REG_STATUS 4'h8
`define TLBD_REG_TIMER 4'h9

// Setting codes; percentages in 0.1 percent, times in 0.1 s.
`define TLBD_OFF_CODE 16'h270f
`define TLBD_ZERO_PCT 18'h01388
`define TLBD_RST_SETTING 16'h270f
`define TLBD_RST_ACTION 2'h0
`define TLBD_RST_TERM 9'h000

// Action select bits and control bits.
`define TLBD_ACT_LIMIT_BIT 0
`define TLBD_ACT_DEV_BIT 1
`define TLBD_CTRL_TRIP_CLR_BIT 0

// Status bit positions.
`define TLBD_ST_UPPER 0
`define TLBD_ST_LOWER 1
`define TLBD_ST_DEV 2
`define TLBD_ST_BREAK 3
`define TLBD_ST_TRIP 4
`define TLBD_ST_STOPPED 5
`define TLBD_ST_SHUTOFF 6
`define TLBD_ST_START 7

// Output terminal codes.
`define TLBD_SEL_LOWER 9'h00e
`define TLBD_SEL_UPPER 9'h00f
`define TLBD_SEL_BREAK 9'h0e7
`define TLBD_SEL_INV 9'h064

// Timing of the waiting time base.
`define TLBD_CLOCK_HZ 50000000
`define TLBD_TICK_TIME_MS 100
// One 0.1 s tick of the 50 MHz clock, sized to the prescaler width.
`define TLBD_TICK_CYCLES 23'h4c4b40
`define TLBD_PRESC_W 23
`endif

// [hdl/tlbd_sync.v]
`timescale 1ns/1ps
`default_nettype none
module tlbd_sync #(
  parameter WIDTH = 3
) (
  // Clock and reset.
  input wire clock,
  input wire resetn,
  // Asynchronous inputs and filtered levels.
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          // A change is taken only once two stages agree.
          if (stage2[i] == stage3[i]) begin
            sync_out[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate
endmodule // tlbd_sync
`default_nettype wire

// [hdl/tlbd_break_timer.v]
`timescale 1ns/1ps
`default_nettype none
`include "tlbd_defines.vh"
module tlbd_break_timer #(
  parameter [`TLBD_PRESC_W-1:0] TICK_CYCLES = `TLBD_TICK_CYCLES
) (
  // Clock and reset.
  input wire clock,
  input wire resetn,
  // Condition and waiting time in 0.1 s.
  input wire run,
  input wire [15:0] wait_time,
  // Result.
  output wire elapsed,
  output reg [15:0] tenths
);
  localparam [`TLBD_PRESC_W-1:0] LAST = TICK_CYCLES - 1'b1;
  reg [`TLBD_PRESC_W-1:0] prescale;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prescale <= {`TLBD_PRESC_W{1'b0}};
      tenths <= 16'h0000;
    end else if (!run) begin
      prescale <= {`TLBD_PRESC_W{1'b0}};
      tenths <= 16'h0000;
    end else if (prescale == LAST) begin
      prescale <= {`TLBD_PRESC_W{1'b0}};
      if (tenths != 16'hffff) begin
        tenths <= tenths + 16'h0001;
      end
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  assign elapsed = run && (tenths >= wait_time);
endmodule // tlbd_break_timer
`default_nettype wire

// [hdl/tlbd_top.v]
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tlbd_defines.vh"
module tlbd_top #(
  parameter [`TLBD_PRESC_W-1:0] TICK_CYCLES = `TLBD_TICK_CYCLES
) (
  // Clock and reset.
  input wire clock,
  input wire resetn,
  // Register port.
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  // Control values from the drive, signed 0.1 percent.
  input wire [15:0] tension_feedback,
  input wire [15:0] control_deviation,
  // PID compensation and winding diameter path.
  input wire [15:0] pid_comp_in,
  output reg [15:0] pid_comp_out,
  input wire [15:0] winding_diameter_in,
  output reg [15:0] winding_diameter_out,
  // Drive state pins.
  input wire motor_stopped,
  input wire output_shutoff,
  input wire start_cmd,
  // Indications.
  output reg upper_limit_flag,
  output reg lower_limit_flag,
  output reg deviation_limit_out,
  output reg break_detect_out,
  output reg pid_limit_trip,
  output reg terminal_out
);

  // Settings written by software.
  reg [15:0] upper_limit_setting;
  reg [15:0] lower_limit_setting;
  reg [15:0] limit_hysteresis_width;
  reg [15:0] break_wait_time;
  reg [15:0] deviation_limit_setting;
  reg [1:0] limit_action_select;
  reg [8:0] output_terminal_select;

  // Synchronised drive state.
  wire [2:0] pins_sync;
  wire stopped_s;
  wire shutoff_s;
  wire start_s;

  // Limit arithmetic.
  wire [17:0] feedback_x;
  wire [17:0] upper_thr;
  wire [17:0] lower_thr;
  wire [17:0] hyst_val;
  wire [17:0] upper_release;
  wire [17:0] lower_release;
  wire [16:0] deviation_abs;
  wire upper_en;
  wire lower_en;
  wire dev_en;
  wire hyst_en;
  wire wait_en;
  wire over_upper;
  wire under_lower;
  wire break_cond;
  wire break_elapsed;
  wire [15:0] timer_tenths;
  wire resume;
  wire trip_set;
  wire trip_clear;
  reg next_terminal;
  reg [15:0] next_rdata;

  // Turns an offset-coded limit (500 percent is zero) into a signed level.
  function [17:0] limit_level;
    input [15:0] setting;
    begin
      limit_level = {2'b00, setting} - `TLBD_ZERO_PCT;
    end
  endfunction

  // Tells whether a setting differs from the code for no function.
  function setting_on;
    input [15:0] setting;
    begin
      setting_on = (setting != `TLBD_OFF_CODE);
    end
  endfunction

  // Magnitude of a signed 16-bit value, one bit wider.
  function [16:0] magnitude;
    input [15:0] value;
    begin
      if (value[15]) begin
        magnitude = 17'h00000 - {value[15], value};
      end else begin
        magnitude = {1'b0, value};
      end
    end
  endfunction

  tlbd_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .async_in({start_cmd, output_shutoff, motor_stopped}),
    .sync_out(pins_sync)
  );

  assign stopped_s = pins_sync[0];
  assign shutoff_s = pins_sync[1];
  assign start_s = pins_sync[2];

  assign upper_en = setting_on(upper_limit_setting);
  assign lower_en = setting_on(lower_limit_setting);
  assign dev_en = setting_on(deviation_limit_setting);
  assign hyst_en = setting_on(limit_hysteresis_width);
  assign wait_en = setting_on(break_wait_time);

  assign feedback_x = {{2{tension_feedback[15]}}, tension_feedback};
  assign upper_thr = limit_level(upper_limit_setting);
  assign lower_thr = limit_level(lower_limit_setting);
  assign hyst_val = hyst_en ? {2'b00, limit_hysteresis_width} : 18'h00000;
  assign upper_release = upper_thr - hyst_val;
  assign lower_release = lower_thr + hyst_val;
  assign deviation_abs = magnitude(control_deviation);

  // Raw comparisons feed the break timer; hysteresis is kept out of it.
  assign over_upper = upper_en &&
    ($signed(feedback_x) > $signed(upper_thr));
  assign under_lower = lower_en &&
    ($signed(feedback_x) < $signed(lower_thr));
  assign break_cond = wait_en && (over_upper || under_lower);

  tlbd_break_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clock(clock),
    .resetn(resetn),
    .run(break_cond),
    .wait_time(break_wait_time),
    .elapsed(break_elapsed),
    .tenths(timer_tenths)
  );

  assign resume = (stopped_s || shutoff_s) && !start_s;

  // Register writes.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      upper_limit_setting <= `TLBD_RST_SETTING;
      lower_limit_setting <= `TLBD_RST_SETTING;
      limit_hysteresis_width <= `TLBD_RST_SETTING;
      break_wait_time <= `TLBD_RST_SETTING;
      deviation_limit_setting <= `TLBD_RST_SETTING;
      limit_action_select <= `TLBD_RST_ACTION;
      output_terminal_select <= `TLBD_RST_TERM;
    end else if (reg_write) begin
      case (reg_addr)
        `TLBD_REG_UPPER: begin
          upper_limit_setting <= reg_wdata;
        end
        `TLBD_REG_LOWER: begin
          lower_limit_setting <= reg_wdata;
        end
        `TLBD_REG_HYST: begin
          limit_hysteresis_width <= reg_wdata;
        end
        `TLBD_REG_WAIT: begin
          break_wait_time <= reg_wdata;
        end
        `TLBD_REG_DEVLIM: begin
          deviation_limit_setting <= reg_wdata;
        end
        `TLBD_REG_ACTION: begin
          limit_action_select <= reg_wdata[1:0];
        end
        `TLBD_REG_TERM: begin
          output_terminal_select <= reg_wdata[8:0];
        end
        default: begin
          limit_action_select <= limit_action_select;
        end
      endcase
    end
  end

  // Limit flags with hysteresis on release.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      upper_limit_flag <= 1'b0;
      lower_limit_flag <= 1'b0;
      deviation_limit_out <= 1'b0;
    end else begin
      if (!upper_en) begin
        upper_limit_flag <= 1'b0;
      end else if ($signed(feedback_x) > $signed(upper_thr)) begin
        upper_limit_flag <= 1'b1;
      end else if ($signed(feedback_x) <= $signed(upper_release)) begin
        upper_limit_flag <= 1'b0;
      end
      if (!lower_en) begin
        lower_limit_flag <= 1'b0;
      end else if ($signed(feedback_x) < $signed(lower_thr)) begin
        lower_limit_flag <= 1'b1;
      end else if ($signed(feedback_x) >= $signed(lower_release)) begin
        lower_limit_flag <= 1'b0;
      end
      // Deviation output.
      deviation_limit_out <= dev_en &&
        (deviation_abs > {1'b0, deviation_limit_setting});
    end
  end

  // Break state, PID compensation and diameter hold.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      break_detect_out <= 1'b0;
      pid_comp_out <= 16'h0000;
      winding_diameter_out <= 16'h0000;
    end else begin
      if (resume) begin
        break_detect_out <= 1'b0;
      end else if (break_elapsed) begin
        break_detect_out <= 1'b1;
      end
      if (break_detect_out || (break_elapsed && !resume)) begin
        pid_comp_out <= 16'h0000;
      end else begin
        pid_comp_out <= pid_comp_in;
      end
      if (!break_detect_out) begin
        winding_diameter_out <= winding_diameter_in;
      end
    end
  end

  // Protective trip, sticky until software clears it.
  assign trip_set =
    (limit_action_select[`TLBD_ACT_LIMIT_BIT] &&
     (upper_limit_flag || lower_limit_flag)) ||
    (limit_action_select[`TLBD_ACT_DEV_BIT] &&
     deviation_limit_out);
  assign trip_clear = reg_write && (reg_addr == `TLBD_REG_CTRL) &&
    reg_wdata[`TLBD_CTRL_TRIP_CLR_BIT];

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pid_limit_trip <= 1'b0;
    end else if (trip_set) begin
      pid_limit_trip <= 1'b1;
    end else if (trip_clear) begin
      pid_limit_trip <= 1'b0;
    end
  end

  // Output terminal routing.
  always @* begin
    next_terminal = 1'b0;
    case (output_terminal_select)
      `TLBD_SEL_LOWER: begin
        next_terminal = lower_limit_flag;
      end
      `TLBD_SEL_UPPER: begin
        next_terminal = upper_limit_flag;
      end
      `TLBD_SEL_BREAK: begin
        next_terminal = break_detect_out;
      end
      `TLBD_SEL_LOWER + `TLBD_SEL_INV: begin
        next_terminal = !lower_limit_flag;
      end
      `TLBD_SEL_UPPER + `TLBD_SEL_INV: begin
        next_terminal = !upper_limit_flag;
      end
      `TLBD_SEL_BREAK + `TLBD_SEL_INV: begin
        next_terminal = !break_detect_out;
      end
      default: begin
        next_terminal = 1'b0;
      end
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      terminal_out <= 1'b0;
    end else begin
      terminal_out <= next_terminal;
    end
  end

  // Register reads; data stand for the one cycle after the strobe.
  always @* begin
    next_rdata = 16'h0000;
    case (reg_addr)
      `TLBD_REG_UPPER: begin
        next_rdata = upper_limit_setting;
      end
      `TLBD_REG_LOWER: begin
        next_rdata = lower_limit_setting;
      end
      `TLBD_REG_HYST: begin
        next_rdata = limit_hysteresis_width;
      end
      `TLBD_REG_WAIT: begin
        next_rdata = break_wait_time;
      end
      `TLBD_REG_DEVLIM: begin
        next_rdata = deviation_limit_setting;
      end
      `TLBD_REG_ACTION: begin
        next_rdata = {14'h0000, limit_action_select};
      end
      `TLBD_REG_TERM: begin
        next_rdata = {7'h00, output_terminal_select};
      end
      `TLBD_REG_STATUS: begin
        next_rdata[`TLBD_ST_UPPER] = upper_limit_flag;
        next_rdata[`TLBD_ST_LOWER] = lower_limit_flag;
        next_rdata[`TLBD_ST_DEV] = deviation_limit_out;
        next_rdata[`TLBD_ST_BREAK] = break_detect_out;
        next_rdata[`TLBD_ST_TRIP] = pid_limit_trip;
        next_rdata[`TLBD_ST_STOPPED] = stopped_s;
        next_rdata[`TLBD_ST_SHUTOFF] = shutoff_s;
        next_rdata[`TLBD_ST_START] = start_s;
      end
      `TLBD_REG_TIMER: begin
        next_rdata = timer_tenths;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // tlbd_top
`default_nettype wire

// [tb/tlbd_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tlbd_defines.vh"
module tlbd_props #(
  parameter [`TLBD_PRESC_W-1:0] TICK_CYCLES = `TLBD_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic resetn,
  // Register writes.
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  // Compensation and diameter path.
  input wire logic [15:0] pid_comp_in,
  input wire logic [15:0] pid_comp_out,
  input wire logic [15:0] winding_diameter_in,
  input wire logic [15:0] winding_diameter_out,
  // Drive state pins.
  input wire logic motor_stopped,
  input wire logic output_shutoff,
  input wire logic start_cmd,
  // Indications.
  input wire logic upper_limit_flag,
  input wire logic lower_limit_flag,
  input wire logic deviation_limit_out,
  input wire logic break_detect_out,
  input wire logic pid_limit_trip
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  wire rel = (motor_stopped | output_shutoff) & !start_cmd;
  wire any_flag = upper_limit_flag | lower_limit_flag | deviation_limit_out;
  sequence s_release;
    rel [*6];
  endsequence
  sequence s_break_run;
    break_detect_out ##1 break_detect_out;
  endsequence
  property p_pid_zero;
    break_detect_out |-> pid_comp_out == 16'h0000;
  endproperty
  a_pid_zero: assert property (p_pid_zero)
    else $error("pid compensation not zero during break");
  property p_pid_pass;
    !break_detect_out && !$past(break_detect_out) |->
      pid_comp_out == $past(pid_comp_in);
  endproperty
  a_pid_pass: assert property (p_pid_pass)
    else $error("pid compensation not passed through");
  property p_diam_hold;
    s_break_run |-> $stable(winding_diameter_out);
  endproperty
  a_diam_hold: assert property (p_diam_hold)
    else $error("diameter moved during break");
  property p_diam_pass;
    !break_detect_out && !$past(break_detect_out) |->
      winding_diameter_out == $past(winding_diameter_in);
  endproperty
  a_diam_pass: assert property (p_diam_pass)
    else $error("diameter not passed through");
  property p_resume;
    s_release |-> !break_detect_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("break not cleared on resume");
  property p_hold;
    $fell(break_detect_out) |-> $past(rel, 4);
  endproperty
  a_hold: assert property (p_hold)
    else $error("break cleared without resume");
  property p_trip_hold;
    pid_limit_trip && !(reg_write && reg_addr == `TLBD_REG_CTRL &&
      reg_wdata[0]) |=> pid_limit_trip;
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip released without clear");
  property p_trip_cause;
    $rose(pid_limit_trip) |-> $past(any_flag);
  endproperty
  a_trip_cause: assert property (p_trip_cause)
    else $error("trip without a limit flag");
  property p_break_cause;
    $rose(break_detect_out) |-> upper_limit_flag | lower_limit_flag;
  endproperty
  a_break_cause: assert property (p_break_cause)
    else $error("break without a limit violation");
endmodule // tlbd_props
bind tlbd_top tlbd_props #(.TICK_CYCLES(TICK_CYCLES)) tlbd_props_inst (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write),
  .pid_comp_in(pid_comp_in), .pid_comp_out(pid_comp_out),
  .winding_diameter_in(winding_diameter_in),
  .winding_diameter_out(winding_diameter_out),
  .motor_stopped(motor_stopped), .output_shutoff(output_shutoff),
  .start_cmd(start_cmd), .upper_limit_flag(upper_limit_flag),
  .lower_limit_flag(lower_limit_flag),
  .deviation_limit_out(deviation_limit_out),
  .break_detect_out(break_detect_out), .pid_limit_trip(pid_limit_trip));
`default_nettype wire

// [tb/test_tlbd_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tlbd_defines.vh"
module test_tlbd_top;
  logic clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic motor_stopped = 1'b0, output_shutoff = 1'b0, start_cmd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, tension_feedback = 16'h0000;
  logic [15:0] control_deviation = 16'h0000, pid_comp_in = 16'h0000;
  logic [15:0] winding_diameter_in = 16'h0000, lfsr = 16'h0030;
  logic [15:0] reg_rdata, pid_comp_out, winding_diameter_out;
  logic upper_limit_flag, lower_limit_flag, deviation_limit_out;
  logic break_detect_out, pid_limit_trip, terminal_out;
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  int up_thr, lo_thr, hy, dl, act, term, k, f, v;
  bit up_on, lo_on, dl_on, mu, ml, md, mt;
  // Upper, lower, hysteresis, deviation limit, action, terminal code.
  int cfg [5][6] = '{'{5500, 4500, 100, 200, 1, 14},
    '{5500, 4500, 9999, 9999, 2, 115}, '{9999, 4500, 0, 0, 3, 15},
    '{5500, 9999, 50, 300, 0, 114}, '{5500, 4500, 100, 9999, 0, 231}};

  always #10 clock = ~clock;

  tlbd_top #(.TICK_CYCLES(23'd10)) tlbd_top_inst (.clock(clock),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tension_feedback(tension_feedback),
    .control_deviation(control_deviation), .pid_comp_in(pid_comp_in),
    .pid_comp_out(pid_comp_out), .winding_diameter_in(winding_diameter_in),
    .winding_diameter_out(winding_diameter_out),
    .motor_stopped(motor_stopped), .output_shutoff(output_shutoff),
    .start_cmd(start_cmd), .upper_limit_flag(upper_limit_flag),
    .lower_limit_flag(lower_limit_flag),
    .deviation_limit_out(deviation_limit_out),
    .break_detect_out(break_detect_out), .pid_limit_trip(pid_limit_trip),
    .terminal_out(terminal_out));

  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input int d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d[15:0];
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input int e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check("rdata", reg_rdata, e[15:0]);
  endtask

  task automatic setup(input int c);
    for (int i = 0; i < 7; i++) begin
      if (i != 3)
        wr(i[3:0], cfg[c][i < 3 ? i : i - 1]);
    end
    up_on = cfg[c][0] != 9999;
    up_thr = cfg[c][0] - 5000;
    lo_on = cfg[c][1] != 9999;
    lo_thr = cfg[c][1] - 5000;
    hy = cfg[c][2] == 9999 ? 0 : cfg[c][2];
    dl_on = cfg[c][3] != 9999;
    dl = cfg[c][3];
    act = cfg[c][4];
    term = cfg[c][5];
  endtask

  // Applies one operating point and compares every indication.
  task automatic step(input int fb, input int dv);
    @(posedge clock);
    tension_feedback <= fb[15:0];
    control_deviation <= dv[15:0];
    pid_comp_in <= lfsr;
    winding_diameter_in <= ~lfsr;
    repeat (2) @(posedge clock);
    #1;
    if (!up_on) mu = 0;
    else if (fb > up_thr) mu = 1;
    else if (fb <= up_thr - hy) mu = 0;
    if (!lo_on) ml = 0;
    else if (fb < lo_thr) ml = 1;
    else if (fb >= lo_thr + hy) ml = 0;
    md = dl_on && (dv > dl || -dv > dl);
    mt = mt || (act[0] && (mu || ml)) || (act[1] && md);
    case (term)
      14: k = ml;
      15: k = mu;
      114: k = !ml;
      115: k = !mu;
      default: k = 0;
    endcase
    check("upper", upper_limit_flag, mu);
    check("lower", lower_limit_flag, ml);
    check("dev", deviation_limit_out, md);
    check("trip", pid_limit_trip, mt);
    check("terminal", terminal_out, k[15:0]);
    check("break", break_detect_out, 0);
    check("pid", pid_comp_out, lfsr);
    check("diam", winding_diameter_out, ~lfsr);
  endtask

  task automatic hold(input int fb, input int n);
    @(posedge clock);
    tension_feedback <= fb[15:0];
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic await(input logic lvl);
    k = 0;
    while (break_detect_out !== lvl && k < 12) begin
      @(posedge clock);
      #1;
      k++;
    end
    check("break", break_detect_out, lvl);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd(i[3:0], i < 5 ? 9999 : 0);
    wr(4'hc, 16'h1234);
    rd(4'hc, 0);
    for (int c = 0; c < 4; c++) begin
      step(0, 0);
      setup(c);
      wr(`TLBD_REG_CTRL, 1);
      mt = 0;
      rd(`TLBD_REG_UPPER, cfg[c][0]);
      repeat (40) begin
        lfsr = next_rand(lfsr);
        f = (lfsr[0] ? 500 : -500) + int'(lfsr[15:1]) % 301 - 150;
        v = int'(lfsr[15:4]) % 601 - 300;
        step(f, v);
      end
    end
    step(0, 0);
    setup(4);
    wr(`TLBD_REG_WAIT, 3);
    start_cmd <= 1'b1;
    winding_diameter_in <= 16'h1234;
    hold(600, 20);
    hold(450, 20);
    check("upper", upper_limit_flag, 1);
    hold(600, 28);
    check("break", break_detect_out, 0);
    rd(`TLBD_REG_TIMER, 2);
    await(1'b1);
    winding_diameter_in <= 16'h5678;
    pid_comp_in <= 16'h7777;
    hold(600, 3);
    check("pid", pid_comp_out, 0);
    check("diam", winding_diameter_out, 16'h1234);
    check("terminal", terminal_out, 1);
    rd(`TLBD_REG_STATUS, 16'h0089);
    wr(`TLBD_REG_TERM, 331);
    repeat (2) @(posedge clock);
    #1;
    check("terminal", terminal_out, 0);
    motor_stopped <= 1'b1;
    hold(0, 10);
    check("break", break_detect_out, 1);
    start_cmd <= 1'b0;
    await(1'b0);
    hold(0, 2);
    check("pid", pid_comp_out, 16'h7777);
    motor_stopped <= 1'b0;
    start_cmd <= 1'b1;
    wr(`TLBD_REG_WAIT, 0);
    hold(-600, 8);
    check("break", break_detect_out, 1);
    check("lower", lower_limit_flag, 1);
    output_shutoff <= 1'b1;
    start_cmd <= 1'b0;
    tension_feedback <= 16'h0000;
    await(1'b0);
    close_out();
  end
endmodule // test_tlbd_top
`default_nettype wire
